// ==== core/dev_ctrl_func.sv ====
`timescale 1ns/100ps
module dev_ctrl_func #(
    parameter bit IS_NETWORK = 1'b1
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        wr_en,
    input  wire logic [15:0] wdata,
    output logic [15:0]      ctrl_value
);
    import dev_ctrl_pkg::*;

    localparam logic [2:0] RD_REQ_RST = IS_NETWORK ? RD_REQ_RST_NET : RD_REQ_RST_OTHER;

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] rst_value;

    // error reporting enables live elsewhere, so bits 3:0 stay zero here
    always_comb begin
        rst_value                            = 16'h0000;
        rst_value[RD_REQ_LSB +: 3]           = RD_REQ_RST;
        rst_value[NO_SNOOP_BIT]              = NO_SNOOP_RST;
        rst_value[AUX_PWR_BIT]               = AUX_PWR_RST;
        rst_value[PHANTOM_BIT]               = PHANTOM_RST;
        rst_value[EXT_TAG_BIT]               = EXT_TAG_RST;
        rst_value[PAYLOAD_LSB +: 3]          = PAYLOAD_RST;
        rst_value[RELAX_ORD_BIT]             = RELAX_ORD_RST;
    end

    // reserved bit 15 is masked out of every write
    assign ctrl_next  = wr_en ? (wdata & DEV_CTRL_WMASK) : ctrl_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_reg <= rst_value;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_value = ctrl_reg;

endmodule

// ==== core/dev_ctrl_pkg.sv ====
package dev_ctrl_pkg;

    // register offsets in the function's configuration space
    localparam logic [7:0]  DEV_CTRL_OFS     = 8'ha8;
    localparam logic [7:0]  GEN_CTRL_OFS     = 8'hb0;
    localparam logic [7:0]  BLOCK_STAT_OFS   = 8'hb4;

    // device_control field positions
    localparam int          RSVD_BIT         = 15;
    localparam int          RD_REQ_LSB       = 12;
    localparam int          NO_SNOOP_BIT     = 11;
    localparam int          AUX_PWR_BIT      = 10;
    localparam int          PHANTOM_BIT      = 9;
    localparam int          EXT_TAG_BIT      = 8;
    localparam int          PAYLOAD_LSB      = 5;
    localparam int          RELAX_ORD_BIT    = 4;

    // device_control values after reset, and its write mask
    localparam logic [2:0]  RD_REQ_RST_NET   = 3'h2;
    localparam logic [2:0]  RD_REQ_RST_OTHER = 3'h0;
    localparam logic [2:0]  PAYLOAD_RST      = 3'h0;
    localparam logic        NO_SNOOP_RST     = 1'h1;
    localparam logic        AUX_PWR_RST      = 1'h0;
    localparam logic        PHANTOM_RST      = 1'h0;
    localparam logic        EXT_TAG_RST      = 1'h0;
    localparam logic        RELAX_ORD_RST    = 1'h1;
    localparam logic [15:0] DEV_CTRL_WMASK   = 16'h7ff0;

    // general_control_reg: bit 0 permits no-snoop
    localparam int          GEN_NS_BIT       = 0;
    localparam logic        GEN_NS_RST       = 1'h1;

    // block status bits
    localparam int          STAT_AUX_BIT     = 0;
    localparam int          STAT_BUSY_BIT    = 1;
    localparam int          STAT_OVERSZ_BIT  = 2;

    // size encodings
    localparam logic [2:0]  RD_REQ_MAX_CODE  = 3'h4;
    localparam logic [2:0]  RD_REQ_FALLBACK  = 3'h0;
    localparam logic [12:0] SIZE_UNIT_BYTES  = 13'h0080;

    function automatic logic [12:0] code_to_bytes(input logic [2:0] code);
        code_to_bytes = SIZE_UNIT_BYTES << code;
    endfunction

endpackage

// ==== core/pcie_device_control_reg.sv ====
`timescale 1ns/100ps
// Summary of operation
// - sixteen-bit read/write control register at a8h
// - each function owns its own register copy
// - read request size field caps read requests
// - read size resets 512 network, 128 otherwise
// - no-snoop needs this bit and general control
// - aux power enable permits aux power draw
// - aux permission is OR over all functions
// - phantom and extended tag bits do nothing
// - accept received payloads up to the smaller of programmed and supported size
// - split transmitted writes at the smaller of programmed and supported payload size
// - relaxed ordering attribute only while enabled
module pcie_device_control_reg #(
    parameter int                 NUM_FUNCS     = 2,
    parameter int                 FUNC_W        = 1,
    parameter logic [NUM_FUNCS-1:0] NET_FUNC_MASK = 2'h3,
    parameter int                 LEN_W         = 16,
    parameter logic [2:0]         PAYLOAD_SUPP  = 3'h1
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic [FUNC_W+7:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    input  wire logic              aux_pme_pin,
    output logic                   aux_power_allowed,
    input  wire logic              xfer_start,
    input  wire logic              xfer_is_read,
    input  wire logic [FUNC_W-1:0] xfer_func,
    input  wire logic [LEN_W-1:0]  xfer_len,
    input  wire logic              xfer_relaxed_ok,
    input  wire logic              xfer_no_snoop_ok,
    output logic                   xfer_busy,
    output logic                   pkt_valid,
    input  wire logic              pkt_ready,
    output logic [LEN_W-1:0]       pkt_len,
    output logic                   pkt_last,
    output logic                   pkt_is_read,
    output logic                   pkt_relaxed,
    output logic                   pkt_no_snoop,
    input  wire logic              rx_valid,
    input  wire logic [FUNC_W-1:0] rx_func,
    input  wire logic [LEN_W-1:0]  rx_len,
    output logic                   rx_accept,
    output logic                   rx_oversize
);
    import dev_ctrl_pkg::*;

    // read request code: reserved codes fall back to the smallest size
    function automatic logic [12:0] rd_req_cap(input logic [15:0] ctrl);
        logic [2:0] code;
        code = ctrl[RD_REQ_LSB +: 3];
        if (code > RD_REQ_MAX_CODE) begin
            code = RD_REQ_FALLBACK;
        end
        rd_req_cap = code_to_bytes(code);
    endfunction

    // payload code: clamped to what the function advertises, guarding
    // against software that ignores the supported size
    function automatic logic [12:0] payload_cap(input logic [15:0] ctrl);
        logic [2:0] code;
        code = ctrl[PAYLOAD_LSB +: 3];
        if (code > PAYLOAD_SUPP) begin
            code = PAYLOAD_SUPP;
        end
        payload_cap = code_to_bytes(code);
    endfunction

    logic [15:0]          ctrl_value [NUM_FUNCS];
    logic [NUM_FUNCS-1:0] gen_ns_reg;
    logic [NUM_FUNCS-1:0] gen_ns_next;
    logic [NUM_FUNCS-1:0] ctrl_wr;
    logic [NUM_FUNCS-1:0] aux_bits;

    // address decode
    wire  [FUNC_W-1:0]    acc_func    = reg_addr[8 +: FUNC_W];
    wire  [7:0]           acc_ofs     = reg_addr[7:0];
    wire                  func_ok     = (int'(acc_func) < NUM_FUNCS);
    wire                  hit_ctrl    = func_ok && (acc_ofs == DEV_CTRL_OFS);
    wire                  hit_gen     = func_ok && (acc_ofs == GEN_CTRL_OFS);
    wire                  hit_stat    = (acc_ofs == BLOCK_STAT_OFS);

    // one register copy per function
    genvar f;
    generate
        for (f = 0; f < NUM_FUNCS; f++) begin : g_func
            assign ctrl_wr[f]     = reg_wr && hit_ctrl && (int'(acc_func) == f);
            assign aux_bits[f]    = ctrl_value[f][AUX_PWR_BIT];
            assign gen_ns_next[f] = (reg_wr && hit_gen && (int'(acc_func) == f)) ?
                                    reg_wdata[GEN_NS_BIT] : gen_ns_reg[f];

            dev_ctrl_func #(
                .IS_NETWORK (NET_FUNC_MASK[f])
            ) u_func (
                .ref_clk    (ref_clk),
                .nrst       (nrst),
                .wr_en      (ctrl_wr[f]),
                .wdata      (reg_wdata),
                .ctrl_value (ctrl_value[f])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            gen_ns_reg <= {NUM_FUNCS{GEN_NS_RST}};
        end else begin
            gen_ns_reg <= gen_ns_next;
        end
    end

    // aux power event pin comes from outside the clock domain
    logic pme_meta_reg;
    logic pme_sync_reg;
    logic aux_allowed_reg;
    logic aux_allowed_next;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pme_meta_reg <= 1'b0;
        end else begin
            pme_meta_reg <= aux_pme_pin;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pme_sync_reg <= 1'b0;
        end else begin
            pme_sync_reg <= pme_meta_reg;
        end
    end

    // any one function's enable suffices, whatever the event signal does
    assign aux_allowed_next = (|aux_bits) || pme_sync_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            aux_allowed_reg <= 1'b0;
        end else begin
            aux_allowed_reg <= aux_allowed_next;
        end
    end

    assign aux_power_allowed = aux_allowed_reg;

    // transfer request: the cap and attributes are frozen at start so a
    // register write mid-transfer cannot change packets already planned
    logic [15:0]      xfer_ctrl;
    logic             xfer_func_ok;
    logic [12:0]      xfer_cap;
    logic             xfer_take;
    logic             split_busy;
    logic             relaxed_next;
    logic             no_snoop_next;
    logic             is_read_reg;
    logic             relaxed_reg;
    logic             no_snoop_reg;

    assign xfer_func_ok  = (int'(xfer_func) < NUM_FUNCS);
    assign xfer_ctrl     = xfer_func_ok ? ctrl_value[xfer_func] : 16'h0000;
    assign xfer_cap      = xfer_is_read ? rd_req_cap(xfer_ctrl)
                                        : payload_cap(xfer_ctrl);
    assign xfer_take     = xfer_start && !split_busy && xfer_func_ok;
    // relaxed ordering only on writes, and only while enabled
    assign relaxed_next  = !xfer_is_read && xfer_relaxed_ok &&
                           xfer_ctrl[RELAX_ORD_BIT];
    assign no_snoop_next = xfer_no_snoop_ok && xfer_ctrl[NO_SNOOP_BIT] &&
                           gen_ns_reg[xfer_func];

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            is_read_reg <= 1'b0;
        end else if (xfer_take) begin
            is_read_reg <= xfer_is_read;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            relaxed_reg <= 1'b0;
        end else if (xfer_take) begin
            relaxed_reg <= relaxed_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            no_snoop_reg <= 1'b0;
        end else if (xfer_take) begin
            no_snoop_reg <= no_snoop_next;
        end
    end

    // the splitter never offers a chunk above the frozen cap
    xfer_splitter #(
        .LEN_W (LEN_W)
    ) u_split (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .start       (xfer_take),
        .total_len   (xfer_len),
        .cap_bytes   (xfer_cap),
        .chunk_ready (pkt_ready),
        .chunk_valid (pkt_valid),
        .chunk_len   (pkt_len),
        .chunk_last  (pkt_last),
        .busy        (split_busy)
    );

    assign xfer_busy    = split_busy;
    assign pkt_is_read  = is_read_reg;
    assign pkt_relaxed  = relaxed_reg;
    assign pkt_no_snoop = no_snoop_reg;

    // receive side size check
    logic        rx_func_ok;
    logic [12:0] rx_cap;
    logic        rx_fits;
    logic        rx_accept_reg;
    logic        rx_over_reg;
    logic        oversz_sticky_reg;
    logic        oversz_clr;
    logic        oversz_sticky_next;

    assign rx_func_ok = (int'(rx_func) < NUM_FUNCS);
    assign rx_cap     = rx_func_ok ? payload_cap(ctrl_value[rx_func]) : 13'h0000;
    assign rx_fits    = rx_func_ok && (rx_len <= LEN_W'(rx_cap));
    assign oversz_clr = reg_wr && hit_stat && reg_wdata[STAT_OVERSZ_BIT];
    // a new oversize event beats a clear in the same cycle
    assign oversz_sticky_next = (rx_valid && !rx_fits) ||
                                (oversz_sticky_reg && !oversz_clr);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_accept_reg <= 1'b0;
        end else begin
            rx_accept_reg <= rx_valid && rx_fits;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_over_reg <= 1'b0;
        end else begin
            rx_over_reg <= rx_valid && !rx_fits;
        end
    end

    // sticky until software writes one to its status bit
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            oversz_sticky_reg <= 1'b0;
        end else begin
            oversz_sticky_reg <= oversz_sticky_next;
        end
    end

    assign rx_accept   = rx_accept_reg;
    assign rx_oversize = rx_over_reg;

    // read data: valid only in the cycle after the read strobe
    logic [15:0] rd_mux;
    logic [15:0] rd_ctrl;
    logic [15:0] rd_gen;
    logic [15:0] rd_stat;
    logic [15:0] stat_value;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    always_comb begin
        stat_value                  = 16'h0000;
        stat_value[STAT_AUX_BIT]    = aux_allowed_reg;
        stat_value[STAT_BUSY_BIT]   = split_busy;
        stat_value[STAT_OVERSZ_BIT] = oversz_sticky_reg;
    end

    // offsets never overlap, so at most one term is non-zero; unmapped
    // offsets read as zero, and so do absent functions at every offset except block status
    assign rd_ctrl    = hit_ctrl ? ctrl_value[acc_func] : 16'h0000;
    assign rd_gen     = hit_gen ? {15'h0000, gen_ns_reg[acc_func]} : 16'h0000;
    assign rd_stat    = hit_stat ? stat_value : 16'h0000;
    assign rd_mux     = rd_ctrl | rd_gen | rd_stat;
    assign rdata_next = reg_rd ? rd_mux : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// ==== core/xfer_splitter.sv ====
`timescale 1ns/100ps
module xfer_splitter #(
    parameter int LEN_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             start,
    input  wire logic [LEN_W-1:0] total_len,
    input  wire logic [12:0]      cap_bytes,
    input  wire logic             chunk_ready,
    output logic                  chunk_valid,
    output logic [LEN_W-1:0]      chunk_len,
    output logic                  chunk_last,
    output logic                  busy
);
    typedef enum logic {SPLIT_IDLE, SPLIT_RUN} split_state_e;

    split_state_e     state_reg;
    logic [LEN_W-1:0] rem_reg;
    logic [LEN_W-1:0] cap_reg;
    logic             valid_reg;
    logic [LEN_W-1:0] len_reg;
    logic             last_reg;
    logic             busy_reg;
    logic [LEN_W-1:0] take;
    logic             advance;

    assign take    = (rem_reg > cap_reg) ? cap_reg : rem_reg;
    // a chunk still on offer holds until the consumer takes it
    assign advance = !valid_reg || chunk_ready;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg <= SPLIT_IDLE;
            rem_reg   <= '0;
            cap_reg   <= '0;
            valid_reg <= 1'b0;
            len_reg   <= '0;
            last_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                SPLIT_IDLE: begin
                    if (start && total_len != '0) begin
                        rem_reg   <= total_len;
                        cap_reg   <= LEN_W'(cap_bytes);
                        busy_reg  <= 1'b1;
                        state_reg <= SPLIT_RUN;
                    end
                end
                SPLIT_RUN: begin
                    if (advance) begin
                        if (rem_reg == '0) begin
                            valid_reg <= 1'b0;
                            last_reg  <= 1'b0;
                            busy_reg  <= 1'b0;
                            state_reg <= SPLIT_IDLE;
                        end else begin
                            valid_reg <= 1'b1;
                            len_reg   <= take;
                            last_reg  <= (rem_reg <= cap_reg);
                            rem_reg   <= rem_reg - take;
                        end
                    end
                end
            endcase
        end
    end

    assign chunk_valid = valid_reg;
    assign chunk_len   = len_reg;
    assign chunk_last  = last_reg;
    assign busy        = busy_reg;

endmodule

// ==== verification/dev_ctrl_props.sv ====
`timescale 1ns/100ps
module dev_ctrl_props #(
    parameter int         NUM_FUNCS    = 2,
    parameter int         FUNC_W       = 1,
    parameter int         LEN_W        = 16,
    parameter logic [2:0] PAYLOAD_SUPP = 3'h1
) (
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic              aux_pme_pin,
    input wire logic              aux_power_allowed,
    input wire logic              xfer_start,
    input wire logic [FUNC_W-1:0] xfer_func,
    input wire logic [LEN_W-1:0]  xfer_len,
    input wire logic              xfer_busy,
    input wire logic              pkt_valid,
    input wire logic              pkt_ready,
    input wire logic [LEN_W-1:0]  pkt_len,
    input wire logic              pkt_last,
    input wire logic              pkt_is_read,
    input wire logic              pkt_relaxed,
    input wire logic              rx_valid,
    input wire logic              rx_accept,
    input wire logic              rx_oversize
);
    // write payload is clamped to the supported size
    localparam int WR_MAX = 128 << PAYLOAD_SUPP;
    localparam int RD_MAX = 2048;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    rsvd_zero_a: assert property (reg_rdata[15] == 1'b0)
        else $error("reserved bit reads one");
    wr_cap_a: assert property (pkt_valid && !pkt_is_read |-> pkt_len <= WR_MAX && pkt_len != 0)
        else $error("write chunk above payload cap");
    rd_cap_a: assert property (pkt_valid && pkt_is_read |-> pkt_len <= RD_MAX && pkt_len != 0)
        else $error("read chunk above request cap");
    pkt_hold_a: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_len) && $stable(pkt_last))
        else $error("chunk dropped while stalled");
    start_busy_a: assert property (xfer_start && !xfer_busy && xfer_func < NUM_FUNCS && xfer_len != 0 |=> xfer_busy ##1 pkt_valid)
        else $error("transfer not started");
    last_release_a: assert property (pkt_valid && pkt_ready && pkt_last |=> !pkt_valid && !xfer_busy)
        else $error("transfer not ended after last chunk");
    rx_answer_a: assert property (rx_valid |=> rx_accept != rx_oversize)
        else $error("receive check missing");
    rx_quiet_a: assert property (!rx_valid |=> !rx_accept && !rx_oversize)
        else $error("receive answer without packet");
    aux_pin_a: assert property (aux_pme_pin [*4] |=> aux_power_allowed)
        else $error("aux pin not honoured");
    read_norelax_a: assert property (pkt_valid && pkt_is_read |-> !pkt_relaxed)
        else $error("relaxed attribute on read");

    cover property (pkt_valid && pkt_ready && pkt_last && !pkt_is_read);
    cover property (pkt_valid && pkt_ready && pkt_last && pkt_is_read);
    cover property (rx_valid ##1 rx_oversize);
endmodule

bind pcie_device_control_reg dev_ctrl_props #(
    .NUM_FUNCS(NUM_FUNCS), .FUNC_W(FUNC_W), .LEN_W(LEN_W), .PAYLOAD_SUPP(PAYLOAD_SUPP)
) u_props (
    .ref_clk, .nrst, .reg_rd, .reg_rdata, .aux_pme_pin, .aux_power_allowed, .xfer_start,
    .xfer_func, .xfer_len, .xfer_busy, .pkt_valid, .pkt_ready, .pkt_len, .pkt_last,
    .pkt_is_read, .pkt_relaxed, .rx_valid, .rx_accept, .rx_oversize
);

// ==== verification/pkt_sink.sv ====
`timescale 1ns/100ps
module pkt_sink (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic slow,
    output logic      pkt_ready
);
    logic ready_reg;

    // slow mode stalls every other cycle so held chunks get exercised
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= slow ? ~ready_reg : 1'b1;
        end
    end

    assign pkt_ready = ready_reg;
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import dev_ctrl_pkg::*;
    logic        ref_clk, nrst, reg_wr, reg_rd, aux_pme_pin, aux_power_allowed, slow;
    logic        xfer_start, xfer_is_read, xfer_func, xfer_relaxed_ok, xfer_no_snoop_ok;
    logic        xfer_busy, pkt_valid, pkt_ready, pkt_last, pkt_is_read, pkt_relaxed;
    logic        pkt_no_snoop, rx_valid, rx_func, rx_accept, rx_oversize;
    logic [8:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, xfer_len, pkt_len, rx_len;
    int          n_mismatch, checked, cycles;

    pcie_device_control_reg uut (
        .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .aux_pme_pin,
        .aux_power_allowed, .xfer_start, .xfer_is_read, .xfer_func, .xfer_len,
        .xfer_relaxed_ok, .xfer_no_snoop_ok, .xfer_busy, .pkt_valid, .pkt_ready, .pkt_len,
        .pkt_last, .pkt_is_read, .pkt_relaxed, .pkt_no_snoop, .rx_valid, .rx_func, .rx_len,
        .rx_accept, .rx_oversize
    );
    pkt_sink sink (.ref_clk, .nrst, .slow, .pkt_ready);

    task automatic complete_run;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] dc(input logic [2:0] rq, input logic ns,
                                       input logic [2:0] pl, input logic ro);
        return {1'b0, rq, ns, 3'h0, pl, ro, 4'h0};
    endfunction

    task automatic wr(input logic f, input logic [7:0] ofs, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= {f, ofs};
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic f, input logic [7:0] ofs, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= {f, ofs};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic run_xfer(input logic rd, input logic f, input int len, input int cap,
                            input logic rel, input logic ns, input logic erel, input logic ens);
        int rem;
        int n;
        rem = len;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (xfer_busy !== 1'b0 && n < 50);
        @(posedge ref_clk);
        xfer_start       <= 1'b1;
        xfer_is_read     <= rd;
        xfer_func        <= f;
        xfer_len         <= len[15:0];
        xfer_relaxed_ok  <= rel;
        xfer_no_snoop_ok <= ns;
        @(posedge ref_clk);
        xfer_start <= 1'b0;
        n = 0;
        while (rem > 0 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
                check(pkt_len, (rem < cap) ? rem : cap);
                check(pkt_last, rem <= cap);
                check({pkt_is_read, pkt_relaxed, pkt_no_snoop}, {rd, erel, ens});
                rem = (rem < cap) ? 0 : rem - cap;
            end
        end
        check(rem, 0);
    endtask

    task automatic t_reset;
        rd_chk(1'b0, DEV_CTRL_OFS, 16'h2810);
        rd_chk(1'b1, DEV_CTRL_OFS, 16'h2810);
        rd_chk(1'b0, GEN_CTRL_OFS, 16'h0001);
        check(aux_power_allowed, 1'b0);
    endtask

    task automatic t_regs;
        wr(1'b0, DEV_CTRL_OFS, 16'hffff);
        rd_chk(1'b0, DEV_CTRL_OFS, 16'h7ff0);
        rd_chk(1'b1, DEV_CTRL_OFS, 16'h2810);
        wr(1'b0, 8'h40, 16'hffff);
        rd_chk(1'b0, 8'h40, 16'h0000);
        wr(1'b0, DEV_CTRL_OFS, 16'h2810);
    endtask

    task automatic t_aux;
        wr(1'b1, DEV_CTRL_OFS, 16'h2c10);
        repeat (3) @(posedge ref_clk);
        #1 check(aux_power_allowed, 1'b1);
        wr(1'b1, DEV_CTRL_OFS, 16'h2810);
        repeat (3) @(posedge ref_clk);
        #1 check(aux_power_allowed, 1'b0);
        @(posedge ref_clk) aux_pme_pin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 check(aux_power_allowed, 1'b1);
        rd_chk(1'b0, BLOCK_STAT_OFS, 16'h0001);
        @(posedge ref_clk) aux_pme_pin <= 1'b0;
    endtask

    task automatic t_write;
        for (int p = 0; p < 2; p++) begin
            wr(1'b0, DEV_CTRL_OFS, dc(3'h2, 1'b1, p[2:0], 1'b1));
            slow <= p[0];
            run_xfer(1'b0, 1'b0, 300, 128 << p, 1'b1, 1'b1, 1'b1, 1'b1);
            run_xfer(1'b0, 1'b0, 256 << p, 128 << p, 1'b1, 1'b1, 1'b1, 1'b1);
        end
    endtask

    task automatic t_read;
        slow <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(1'b1, DEV_CTRL_OFS, dc(c[2:0], 1'b1, 3'h0, 1'b1));
            run_xfer(1'b1, 1'b1, 2100, (c > 4) ? 128 : 128 << c, 1'b1, 1'b1, 1'b0, 1'b1);
        end
    endtask

    task automatic t_attr;
        slow <= 1'b0;
        wr(1'b0, DEV_CTRL_OFS, dc(3'h2, 1'b1, 3'h0, 1'b0));
        run_xfer(1'b0, 1'b0, 100, 128, 1'b1, 1'b1, 1'b0, 1'b1);
        wr(1'b0, GEN_CTRL_OFS, 16'h0000);
        run_xfer(1'b0, 1'b0, 100, 128, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(1'b0, GEN_CTRL_OFS, 16'h0001);
        wr(1'b0, DEV_CTRL_OFS, dc(3'h2, 1'b0, 3'h0, 1'b1) | 16'h0300);
        run_xfer(1'b0, 1'b0, 300, 128, 1'b1, 1'b1, 1'b1, 1'b0);
    endtask

    task automatic rx_chk(input logic f, input logic [15:0] len, input logic ok);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_func  <= f;
        rx_len   <= len;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        #1 check({rx_accept, rx_oversize}, {ok, ~ok});
    endtask

    task automatic t_rx;
        wr(1'b1, DEV_CTRL_OFS, dc(3'h2, 1'b1, 3'h1, 1'b1));
        rx_chk(1'b0, 16'd128, 1'b1);
        rx_chk(1'b0, 16'd129, 1'b0);
        rx_chk(1'b1, 16'd256, 1'b1);
        rd_chk(1'b0, BLOCK_STAT_OFS, 16'h0004);
        wr(1'b0, BLOCK_STAT_OFS, 16'h0004);
        rd_chk(1'b0, BLOCK_STAT_OFS, 16'h0000);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // cuts a hang short well beyond the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run;
        end
    end

    initial begin
        {nrst, reg_wr, reg_rd, aux_pme_pin, slow, xfer_start, xfer_is_read} = '0;
        {xfer_func, xfer_relaxed_ok, xfer_no_snoop_ok, rx_valid, rx_func} = '0;
        {reg_addr, reg_wdata, xfer_len, rx_len} = '0;
        {n_mismatch, checked, cycles} = '0;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_regs;
        t_aux;
        t_write;
        t_read;
        t_attr;
        t_rx;
        complete_run;
    end
endmodule
